/* psta_pkg.sv */
/*
 * Package for the program space table access block: register offsets,
 * field layouts, reset values, table operation codes and carrier structs.
 * Assumes a single core clock and a synchronous active-low reset.
 */
`default_nettype none
package psta_pkg;
   // Register bus geometry.
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   // Register offsets on the plain register port.
   localparam logic [3:0] OFS_TABLE_PAGE = 4'h0;
   localparam logic [3:0] OFS_NVM_KEY = 4'h1;
   localparam logic [3:0] OFS_SRC_HIGH = 4'h2;
   localparam logic [3:0] OFS_SRC_LOW = 4'h3;
   // Field layouts and reset values.
   localparam int unsigned PAGE_W = 8;
   localparam int unsigned PAGE_CFG_BIT = 7;
   localparam int unsigned KEY_W = 8;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] SRC_HIGH_RESET = 8'h00;
   localparam logic [15:0] SRC_LOW_RESET = 16'h0000;
   localparam logic [15:0] SRC_LOW_MASK = 16'hFFFE;
   localparam logic [15:0] READ_ZERO = 16'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Program word geometry.
   localparam int unsigned PWORD_W = 24;
   localparam int unsigned PADDR_W = 16;
   localparam logic [15:0] PADDR_STEP = 16'h0002;
   // Table operations issued by the core.
   typedef enum logic [1:0] {
      TBL_RD_LOW, TBL_RD_HIGH, TBL_WT_LOW, TBL_WT_HIGH
   } psta_op_type;
   // Register bus request.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } psta_reg_req_type;
   // Table instruction request from the core.
   typedef struct packed {
      logic valid;
      psta_op_type op;
      logic byte_mode;
      logic [15:0] addr;
      logic [15:0] wdata;
   } psta_tbl_req_type;
   // Program memory port toward the array.
   typedef struct packed {
      logic rd;
      logic wr;
      logic cfg_space;
      logic [7:0] page;
      logic [15:0] addr;
      logic [23:0] wdata;
      logic [2:0] wbe;
   } psta_mem_req_type;
endpackage : psta_pkg
`default_nettype wire

/* psta_read_align.sv */
/*
 * Read alignment: turns a 24-bit program word into the 16-bit data word
 * of a low or high table read, in word or byte mode.
 * Purely combinational; the caller registers the result.
 */
`default_nettype none
module psta_read_align (
   input wire logic [23:0] i_pword,
   input wire logic i_high,
   input wire logic i_byte_mode,
   input wire logic i_byte_sel,
   output logic [15:0] o_data
);
   import psta_pkg::*;

   // Select the lane; the high space has a phantom byte that reads zero.
   always_comb begin
      o_data = READ_ZERO;
      if (!i_high) begin
         if (!i_byte_mode) begin
            o_data = i_pword[15:0]; // RL1
         end else begin
            o_data = {BYTE_ZERO, i_byte_sel ? i_pword[15:8] : i_pword[7:0]}; // RL2
         end
      end else begin
         if (!i_byte_mode || !i_byte_sel) begin
            o_data = {BYTE_ZERO, i_pword[23:16]}; // RL3 RL4
         end else begin
            o_data = READ_ZERO; // RL4
         end
      end
   end
endmodule : psta_read_align
`default_nettype wire

/* psta_table_access.sv */
/*
 * Program space table access block: table reads and writes of program
 * memory, the table page register and the flash key and source address
 * registers. Assumes the program array answers a read in the next cycle
 * and that the core issues at most one table request per cycle.
 */
`default_nettype none
// Summary of operation
// RL1: Word low read returns program bits 15..0.
// RL2: Byte low read picks byte by select.
// RL3: Word high read gives bits 23..16, phantom zero.
// RL4: Byte high read: phantom byte reads zero.
// RL5: Low ops reach low word; high ops upper byte.
// RL6: Addresses step two per program word.
// RL7: Every table op uses table page register.
// RL8: Page bit 7 selects configuration space.
// RL9: Table writes support byte or word.
// RL10: Key register eight bits, write only, reset zero.
// RL11: Upper source address byte readable and writable.
// RL12: Lower source address bits 15..1, bit 0 zero.
// RL13: Key register always reads back zero.
module psta_table_access (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire psta_pkg::psta_reg_req_type i_reg,
   output logic [15:0] o_reg_rdata,
   input wire psta_pkg::psta_tbl_req_type i_tbl,
   output logic o_tbl_done,
   output logic [15:0] o_tbl_rdata,
   output psta_pkg::psta_mem_req_type o_mem,
   input wire logic [23:0] i_mem_rdata,
   output logic [7:0] o_nvm_unlock_key,
   output logic [23:0] o_nvm_source_address
);
   import psta_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} psta_state_type;

   typedef struct packed {
      psta_state_type st;
      logic [7:0] page;
      logic [7:0] key;
      logic [7:0] src_h;
      logic [15:0] src_l;
      logic [15:0] rdata;
      logic high;
      logic byte_mode;
      logic byte_sel;
      logic done;
      logic [15:0] tbl_rdata;
      psta_mem_req_type mem;
   } psta_regs_type;

   psta_regs_type s_q;
   psta_regs_type s_d;
   logic [15:0] aligned;

   // Lane alignment of the word returned by the program array.
   psta_read_align u_align (
      .i_pword(i_mem_rdata),
      .i_high(s_q.high),
      .i_byte_mode(s_q.byte_mode),
      .i_byte_sel(s_q.byte_sel),
      .o_data(aligned)
   );

   // Next state: register port, table sequencer and memory request.
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.mem.rd = 1'b0;
      s_d.mem.wr = 1'b0;
      s_d.rdata = READ_ZERO;
      if (i_reg.wr) begin
         unique case (i_reg.addr)
            OFS_TABLE_PAGE: s_d.page = i_reg.wdata[PAGE_W-1:0];
            OFS_NVM_KEY: s_d.key = i_reg.wdata[KEY_W-1:0]; // RL10
            OFS_SRC_HIGH: s_d.src_h = i_reg.wdata[7:0]; // RL11
            OFS_SRC_LOW: s_d.src_l = i_reg.wdata & SRC_LOW_MASK; // RL12
            default: ;
         endcase
      end
      if (i_reg.rd) begin
         unique case (i_reg.addr)
            OFS_TABLE_PAGE: s_d.rdata = {BYTE_ZERO, s_q.page};
            OFS_NVM_KEY: s_d.rdata = READ_ZERO; // RL13
            OFS_SRC_HIGH: s_d.rdata = {BYTE_ZERO, s_q.src_h}; // RL11
            OFS_SRC_LOW: s_d.rdata = s_q.src_l & SRC_LOW_MASK; // RL12
            default: s_d.rdata = READ_ZERO;
         endcase
      end
      unique case (s_q.st)
         ST_IDLE: begin
            if (i_tbl.valid) begin
               s_d.mem.page = s_q.page; // RL7
               s_d.mem.cfg_space = s_q.page[PAGE_CFG_BIT]; // RL8
               // Bit 0 is the byte select; the word index is the even address.
               s_d.mem.addr = {i_tbl.addr[15:1], 1'b0}; // RL6
               s_d.high = (i_tbl.op == TBL_RD_HIGH) || (i_tbl.op == TBL_WT_HIGH); // RL5
               s_d.byte_mode = i_tbl.byte_mode;
               s_d.byte_sel = i_tbl.addr[0];
               if (i_tbl.op == TBL_RD_LOW || i_tbl.op == TBL_RD_HIGH) begin
                  s_d.mem.rd = 1'b1;
                  s_d.st = ST_READ;
               end else begin
                  s_d.mem.wr = 1'b1;
                  s_d.st = ST_DONE;
                  if (i_tbl.op == TBL_WT_LOW) begin
                     s_d.mem.wdata = {BYTE_ZERO, i_tbl.wdata};
                     if (!i_tbl.byte_mode) begin
                        s_d.mem.wbe = 3'b011; // RL9
                     end else if (i_tbl.addr[0]) begin
                        s_d.mem.wdata = {BYTE_ZERO, i_tbl.wdata[7:0], BYTE_ZERO};
                        s_d.mem.wbe = 3'b010; // RL9
                     end else begin
                        s_d.mem.wbe = 3'b001; // RL9
                     end
                  end else begin
                     // High write reaches only the upper byte; phantom writes are dropped.
                     s_d.mem.wdata = {i_tbl.wdata[7:0], READ_ZERO}; // RL5
                     s_d.mem.wbe = (i_tbl.byte_mode && i_tbl.addr[0]) ? 3'b000 : 3'b100; // RL9
                  end
               end
            end
         end
         ST_READ: begin
            s_d.st = ST_DONE;
         end
         ST_DONE: begin
            // The array answers one cycle after the strobe, so the lane is taken only here.
            s_d.tbl_rdata = s_q.mem.wr ? READ_ZERO : aligned; // RL1 RL2 RL3 RL4
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
         end
      endcase
   end

   // All state in one register; source address has no documented reset.
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.page <= PAGE_RESET;
         s_q.key <= KEY_RESET; // RL10
         s_q.src_h <= SRC_HIGH_RESET;
         s_q.src_l <= SRC_LOW_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_reg_rdata = s_q.rdata;
   assign o_tbl_done = s_q.done;
   assign o_tbl_rdata = s_q.tbl_rdata;
   assign o_mem = s_q.mem;
   assign o_nvm_unlock_key = s_q.key;
   assign o_nvm_source_address = {s_q.src_h, s_q.src_l};

   // Key register never shows its content on the bus.
   property p_key_hidden;
      @(posedge i_core_clk) disable iff (!i_resetn)
         i_reg.rd && i_reg.addr == OFS_NVM_KEY |=> o_reg_rdata == READ_ZERO;
   endproperty
   a_key_hidden: assert property (p_key_hidden) else $error("key register read not zero"); // RL13

   // Low source address bit 0 always reads zero.
   property p_src_low_bit0;
      @(posedge i_core_clk) disable iff (!i_resetn)
         i_reg.rd && i_reg.addr == OFS_SRC_LOW |=> o_reg_rdata[0] == 1'b0;
   endproperty
   a_src_low_bit0: assert property (p_src_low_bit0) else $error("source low bit 0 set"); // RL12

   // Upper byte of the upper source address reads zero, low byte echoes the write.
   property p_src_high;
      @(posedge i_core_clk) disable iff (!i_resetn)
         i_reg.wr && i_reg.addr == OFS_SRC_HIGH ##1 i_reg.rd && i_reg.addr == OFS_SRC_HIGH && !i_reg.wr
         |=> o_reg_rdata == {BYTE_ZERO, $past(i_reg.wdata[7:0], 2)};
   endproperty
   a_src_high: assert property (p_src_high) else $error("source high readback wrong"); // RL11

   // Key write lands in the key output.
   property p_key_write;
      @(posedge i_core_clk) disable iff (!i_resetn)
         i_reg.wr && i_reg.addr == OFS_NVM_KEY |=> o_nvm_unlock_key == $past(i_reg.wdata[7:0]);
   endproperty
   a_key_write: assert property (p_key_write) else $error("key not stored"); // RL10

   // A table request carries the page and its space flag.
   property p_page_used;
      @(posedge i_core_clk) disable iff (!i_resetn)
         s_q.st == ST_IDLE && i_tbl.valid |=>
            o_mem.page == $past(s_q.page) && o_mem.cfg_space == $past(s_q.page[PAGE_CFG_BIT]);
   endproperty
   a_page_used: assert property (p_page_used) else $error("page not applied"); // RL7 RL8

   // A read finishes three cycles after its request.
   sequence s_rd_req;
      s_q.st == ST_IDLE && i_tbl.valid && (i_tbl.op == TBL_RD_LOW || i_tbl.op == TBL_RD_HIGH);
   endsequence
   property p_rd_done;
      @(posedge i_core_clk) disable iff (!i_resetn)
         s_rd_req |=> o_mem.rd ##1 !o_tbl_done ##1 o_tbl_done;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("table read timing wrong"); // RL5

   // Word low read returns the low program word.
   property p_word_low;
      @(posedge i_core_clk) disable iff (!i_resetn)
         s_q.st == ST_DONE && !s_q.mem.wr && !s_q.high && !s_q.byte_mode
         |=> o_tbl_rdata == $past(i_mem_rdata[15:0]);
   endproperty
   a_word_low: assert property (p_word_low) else $error("word low read wrong"); // RL1

   // High reads keep the phantom byte zero.
   property p_phantom;
      @(posedge i_core_clk) disable iff (!i_resetn)
         s_q.st == ST_DONE && !s_q.mem.wr && s_q.high |=> o_tbl_rdata[15:8] == BYTE_ZERO;
   endproperty
   a_phantom: assert property (p_phantom) else $error("phantom byte not zero"); // RL3 RL4

   // Word accesses go to the even word address.
   property p_even_addr;
      @(posedge i_core_clk) disable iff (!i_resetn)
         o_mem.rd || o_mem.wr |-> o_mem.addr[0] == 1'b0;
   endproperty
   a_even_addr: assert property (p_even_addr) else $error("odd word address"); // RL6

   // Byte low write enables one lane only.
   property p_byte_write;
      @(posedge i_core_clk) disable iff (!i_resetn)
         s_q.st == ST_IDLE && i_tbl.valid && i_tbl.op == TBL_WT_LOW && i_tbl.byte_mode
         |=> o_mem.wr && $onehot(o_mem.wbe);
   endproperty
   a_byte_write: assert property (p_byte_write) else $error("byte write lanes wrong"); // RL9
endmodule : psta_table_access
`default_nettype wire

/* psta_mem_model.sv */
/*
 * Program memory model for the table access bench: 256 words of 24 bits.
 * Assumes one clock and that a read is answered in the cycle after the request.
 */
`default_nettype none
module psta_mem_model
   import psta_pkg::*;
(
   input wire logic i_core_clk,
   input wire psta_pkg::psta_mem_req_type i_mem,
   output logic [23:0] o_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] mem [256];
   logic [7:0] idx;
   // Word index from space, page and word address; byte addresses step by two per word.
   assign idx = {i_mem.cfg_space, i_mem.page[2:0], i_mem.addr[4:1]};
   // Data stand in the answer cycle; otherwise the output inverts each cycle, so stale data show again every second cycle.
   always @(posedge i_core_clk) begin
      for (int b = 0; b < 3; b++) begin
         if (i_mem.wr && i_mem.wbe[b]) begin
            mem[idx][8*b +: 8] <= i_mem.wdata[8*b +: 8];
         end
      end
      o_rdata <= i_mem.rd ? mem[idx] : ~o_rdata;
   end
   // Unwritten words hold a pattern, not zero, so a missed write is seen.
   initial begin
      o_rdata = 24'h00_0000;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 24'hA5_C35A ^ 24'(i);
      end
   end
endmodule : psta_mem_model
`default_nettype wire

/* psta_table_access_bench.sv */
/*
 * Self-checking bench for the table access block with a program memory model.
 * Assumes the package offsets and the one-cycle memory answer of the model.
 */
`default_nettype none
module psta_table_access_bench;
   import psta_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] A = 16'h0024;
   logic clk;
   logic resetn;
   psta_reg_req_type rq;
   psta_tbl_req_type tbl;
   psta_mem_req_type mem_req;
   logic [15:0] reg_rdata, tbl_rdata;
   logic [23:0] mem_rdata, src_addr;
   logic [7:0] key_out, page;
   logic done;
   logic [15:0] r;
   int failures = 0;
   int compares = 0;

   psta_table_access psta_table_access_inst (.i_core_clk(clk), .i_resetn(resetn), .i_reg(rq),
      .o_reg_rdata(reg_rdata), .i_tbl(tbl), .o_tbl_done(done), .o_tbl_rdata(tbl_rdata), .o_mem(mem_req),
      .i_mem_rdata(mem_rdata), .o_nvm_unlock_key(key_out), .o_nvm_source_address(src_addr));
   psta_mem_model psta_mem_model_inst (.i_core_clk(clk), .i_mem(mem_req), .o_rdata(mem_rdata));

   // The clock toggles every half period of 12.5 ns.
   always #12.5 clk = ~clk;

   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim

   // Register accesses are one-cycle strobes; read data are looked at only in the next cycle.
   task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge clk);
      rq <= '{wr, ~wr, a, d};
      @(posedge clk);
      rq <= '0;
      #1;
      if (!wr) check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask : reg_acc

   // One table request; the memory side is judged in the cycle after the request is taken.
   task automatic tbl_op(input psta_op_type op, input logic bm, input logic [15:0] a, input logic [15:0] wd,
                         input logic [2:0] wbe, output logic [15:0] rd);
      int n;
      @(posedge clk);
      tbl <= '{1'b1, op, bm, a, wd};
      @(posedge clk);
      tbl.valid <= 1'b0;
      #1;
      check("mem_strobe", 24'h1, (op inside {TBL_RD_LOW, TBL_RD_HIGH}) ? mem_req.rd : mem_req.wr);
      check("mem_addr", {8'h00, a[15:1], 1'b0}, {8'h00, mem_req.addr});
      check("mem_page", {16'h0000, page}, {16'h0000, mem_req.page});
      check("mem_cfg", {23'h0, page[7]}, {23'h0, mem_req.cfg_space});
      if (op inside {TBL_WT_LOW, TBL_WT_HIGH}) check("mem_wbe", {21'h0, wbe}, {21'h0, mem_req.wbe});
      n = 0;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("tbl_done", 24'h1, {23'h0, done});
      rd = tbl_rdata;
   endtask : tbl_op

   task automatic rd_chk(input psta_op_type op, input logic bm, input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] v;
      tbl_op(op, bm, a, 16'h0000, 3'b000, v);
      check("tbl_rdata", {8'h00, exp}, {8'h00, v});
   endtask : rd_chk

   // Reset values, write-only key, source address readback with an even low word and an unmapped read.
   task automatic t_regs;
      reg_acc(0, OFS_TABLE_PAGE, 0, 16'h0000);
      reg_acc(0, OFS_NVM_KEY, 0, 16'h0000);
      reg_acc(0, OFS_SRC_HIGH, 0, 16'h0000);
      reg_acc(0, OFS_SRC_LOW, 0, 16'h0000);
      reg_acc(1, OFS_NVM_KEY, 16'hFFA5, 0);
      check("key_out", 24'h00_00A5, {16'h0000, key_out});
      reg_acc(0, OFS_NVM_KEY, 0, 16'h0000);
      reg_acc(1, OFS_SRC_HIGH, 16'hFFC3, 0);
      reg_acc(0, OFS_SRC_HIGH, 0, 16'h00C3);
      reg_acc(1, OFS_SRC_LOW, 16'h1234, 0);
      reg_acc(0, OFS_SRC_LOW, 0, 16'h1234);
      check("src_addr", 24'hC3_1234, src_addr);
      reg_acc(0, 4'hF, 0, 16'h0000);
      // Write and read with no gap between the strobes.
      @(posedge clk);
      rq <= '{1'b1, 1'b0, OFS_SRC_HIGH, 16'h005A};
      @(posedge clk);
      rq <= '{1'b0, 1'b1, OFS_SRC_HIGH, 16'h0000};
      @(posedge clk);
      rq <= '0;
      #1;
      check("reg_rdata", 24'h00_005A, {8'h00, reg_rdata});
   endtask : t_regs

   // The same address in user and configuration space, read back in every mode.
   task automatic t_table;
      logic [7:0] pg [2] = '{8'h05, 8'h85};
      foreach (pg[k]) begin
         page = pg[k];
         reg_acc(1, OFS_TABLE_PAGE, {8'h00, page}, 0);
         reg_acc(0, OFS_TABLE_PAGE, 0, {8'h00, page});
         tbl_op(TBL_WT_LOW, 0, A, 16'h1357 ^ {page, page}, 3'b011, r);
         tbl_op(TBL_WT_HIGH, 0, A, {8'h00, page ^ 8'h3C}, 3'b100, r);
      end
      foreach (pg[k]) begin
         page = pg[k];
         reg_acc(1, OFS_TABLE_PAGE, {8'h00, page}, 0);
         rd_chk(TBL_RD_LOW, 0, A, 16'h1357 ^ {page, page});
         rd_chk(TBL_RD_LOW, 1, A, {8'h00, 8'h57 ^ page});
         rd_chk(TBL_RD_LOW, 1, A | 16'h0001, {8'h00, 8'h13 ^ page});
         rd_chk(TBL_RD_HIGH, 0, A, {8'h00, page ^ 8'h3C});
         rd_chk(TBL_RD_HIGH, 1, A, {8'h00, page ^ 8'h3C});
         rd_chk(TBL_RD_HIGH, 1, A | 16'h0001, 16'h0000);
      end
   endtask : t_table

   // Byte writes in both halves; the phantom byte takes nothing.
   task automatic t_bytes;
      tbl_op(TBL_WT_LOW, 1, A | 16'h0001, 16'hABAB, 3'b010, r);
      tbl_op(TBL_WT_LOW, 1, A, 16'h00CD, 3'b001, r);
      tbl_op(TBL_WT_HIGH, 1, A | 16'h0001, 16'h0011, 3'b000, r);
      tbl_op(TBL_WT_HIGH, 1, A, 16'h0077, 3'b100, r);
      rd_chk(TBL_RD_LOW, 0, A, 16'hABCD);
      rd_chk(TBL_RD_HIGH, 0, A, 16'h0077);
   endtask : t_bytes

   // Reset is held for 16 cycles, then the scenarios run in turn.
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      rq = '0;
      tbl = '0;
      page = 8'h00;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_table();
      t_bytes();
      end_sim();
   end

   // The scenarios need about 120 cycles; this cuts a hang short well beyond that.
   initial begin
      #100000;
      failures++;
      end_sim();
   end
endmodule : psta_table_access_bench
`default_nettype wire
